// ---- hdl/scp_pkg.sv ----
// scp_pkg: shared constants of the serial control port, slave and master ends
// assumes: both ends run on the same system clock domain family
package scp_pkg;
    localparam int NIB_W        = 4;
    localparam int BYTE_W       = 8;
    localparam int NIB_ADDR_W   = 3;
    localparam int BYTE_ADDR_W  = 4;
    localparam int NIB_COUNT    = 8;
    localparam int BYTE_COUNT   = 16;
    localparam logic [2:0] PTR_ADDR = 3'h7;
    localparam logic DIR_READ   = 1'b1;
    localparam logic DIR_WRITE  = 1'b0;
    localparam int HEAD_BITS    = 4;
    localparam int EXCH_BITS    = 8;
    localparam int FLOAT_EDGES  = 33;
    localparam int CNT_W        = 6;
    localparam int SYS_PERIOD_PS   = 4000;
    localparam int LINK_MAX_KHZ    = 4096;
    // master half period in system cycles, rounded up so the rate stays at or below the ceiling
    localparam int LINK_MIN_PERIOD_PS = (1000000000 + LINK_MAX_KHZ - 1) / LINK_MAX_KHZ;
    localparam int LINK_HALF_CYC = (LINK_MIN_PERIOD_PS + 2 * SYS_PERIOD_PS - 1) / (2 * SYS_PERIOD_PS);
    localparam logic [7:0] NIB_RESET  = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] NIB_RO_MASK  = 8'h00;
    localparam logic [15:0] BYTE_RO_MASK = 16'h0000;
endpackage : scp_pkg

// ---- hdl/scp_if.sv ----
// scp_if: four-wire serial control port between master and slave
// assumes: master end resolves the serial output wire from its enable, reading a floated output as 1
`timescale 1ns/1ps
`default_nettype none
interface scp_if;
    logic port_shift_clock;
    logic port_select_n;
    logic port_serial_in;
    logic port_serial_out;
    logic port_serial_out_oe_n;
    modport slave  (input port_shift_clock, input port_select_n, input port_serial_in,
                    output port_serial_out, output port_serial_out_oe_n);
    modport master (output port_shift_clock, output port_select_n, output port_serial_in,
                    input port_serial_out, input port_serial_out_oe_n);
endinterface : scp_if
`default_nettype wire

// ---- hdl/scp_slave.sv ----
// Summary of operation
// - first bit is direction, 0 means write
// - address 7 selects pointer, byte operation
// - next four bits load byte pointer
// - byte write takes eight bits into register
// - output floats on write; read-only unchanged
// - split write: second exchange carries data
// - read data leaves on falling edges, MSB first
// - nibble read drives MSB after fourth edge
// - byte read drives MSB after eighth edge
// - read is 1; three address bits follow
// - last four bits: data or byte pointer
// - input ignored while driving or deselected
// - input sampled on shift clock rising edges
// - master keeps shift clock at most 4.096 MHz
// - clock edges ignored while deselected
// - master selects for 8 or 16 periods
// - deselect aborts and floats output at once
// - 33 high-input edges enter float test mode
// - float mode ends on deselect or low input
// - port needs only the master's clock; here the pins are oversampled on i_clk_sys
// - device is always slave of the port
// - nibble write stores four data bits
// - split read presents MSB on reselect
// scp_slave: device end, registers held in flip-flops, link pins oversampled
// assumes: i_clk_sys much faster than port shift clock; pins asynchronous
`timescale 1ns/1ps
`default_nettype none
module scp_slave (
    input  wire logic          i_clk_sys,
    input  wire logic          i_rst_n,
    input  wire logic          i_clk_en,
    scp_if.slave               port,
    input  wire logic [2:0]    i_user_nib_sel,
    input  wire logic [3:0]    i_user_byte_sel,
    output logic      [3:0]    o_user_nib,
    output logic      [7:0]    o_user_byte,
    output logic               o_output_float_test_mode
);
    typedef enum logic [1:0] {
        SCP_IDLE  = 2'b00,
        SCP_SHIFT = 2'b01,
        SCP_HOLD  = 2'b11
    } scp_state_t;

    localparam logic [7:0]  NIB_RO  = scp_pkg::NIB_RO_MASK;
    localparam logic [15:0] BYTE_RO = scp_pkg::BYTE_RO_MASK;

    // two-stage synchronisers for the three pins
    logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic       clk_d_ff, nxt_clk_d;
    logic       sclk_s, sel_n_s, sin_s, rise, fall;

    scp_state_t  state_ff, nxt_state;
    logic [4:0]  bitcnt_ff, nxt_bitcnt;
    logic [7:0]  sh_ff, nxt_sh;
    logic [2:0]  naddr_ff, nxt_naddr;
    logic        dir_ff, nxt_dir;
    logic        pend_ff, nxt_pend;
    logic [3:0]  byte_pointer_nibble_ff, nxt_ptr;
    logic [3:0]  nib_ff [scp_pkg::NIB_COUNT];
    logic [3:0]  nxt_nib [scp_pkg::NIB_COUNT];
    logic [7:0]  byte_ff [scp_pkg::BYTE_COUNT];
    logic [7:0]  nxt_byte [scp_pkg::BYTE_COUNT];
    logic [7:0]  tx_ff, nxt_tx;
    logic [3:0]  txleft_ff, nxt_txleft;
    logic        out_ff, nxt_out, oe_n_ff, nxt_oe_n;
    logic [5:0]  hicnt_ff, nxt_hicnt;
    logic        float_ff, nxt_float;
    logic [3:0]  unib_ff, nxt_unib;
    logic [7:0]  ubyte_ff, nxt_ubyte;

    assign sclk_s  = sync2_ff[0];
    assign sel_n_s = sync2_ff[1];
    assign sin_s   = sync2_ff[2];
    assign rise    = sclk_s & ~clk_d_ff;
    assign fall    = ~sclk_s & clk_d_ff;

    always_comb begin
        nxt_sync1 = {port.port_serial_in, port.port_select_n, port.port_shift_clock};
        nxt_sync2 = sync1_ff;
        nxt_clk_d = sclk_s;
        nxt_state = state_ff;
        nxt_bitcnt = bitcnt_ff;
        nxt_sh = sh_ff;
        nxt_naddr = naddr_ff;
        nxt_dir = dir_ff;
        nxt_pend = pend_ff;
        nxt_ptr = byte_pointer_nibble_ff;
        nxt_nib = nib_ff;
        nxt_byte = byte_ff;
        nxt_tx = tx_ff;
        nxt_txleft = txleft_ff;
        nxt_out = out_ff;
        nxt_oe_n = oe_n_ff;
        nxt_hicnt = hicnt_ff;
        nxt_float = float_ff;
        nxt_unib = nib_ff[i_user_nib_sel];
        nxt_ubyte = byte_ff[i_user_byte_sel];
        if (sel_n_s) begin
            // deselect aborts and floats the output; pointer and direction survive  
            nxt_oe_n = 1'b1;
            nxt_txleft = '0;
            nxt_float = 1'b0;
            nxt_hicnt = '0;
            nxt_bitcnt = '0;
            nxt_state = pend_ff ? SCP_HOLD : SCP_IDLE;
        end else begin
            if (state_ff == SCP_HOLD && pend_ff && dir_ff == scp_pkg::DIR_READ
                    && bitcnt_ff == '0 && txleft_ff == '0) begin
                // second half of split read: MSB appears on reselect
                nxt_tx = byte_ff[byte_pointer_nibble_ff] << 1;
                nxt_out = byte_ff[byte_pointer_nibble_ff][scp_pkg::BYTE_W-1];
                nxt_oe_n = 1'b0;
                nxt_txleft = 4'(scp_pkg::BYTE_W - 1);
                nxt_pend = 1'b0;
                nxt_state = SCP_SHIFT;
            end
            if (!sin_s) begin
                nxt_float = 1'b0;
                nxt_hicnt = '0;
            end else if (rise) begin
                if (hicnt_ff < 6'(scp_pkg::FLOAT_EDGES))
                    nxt_hicnt = hicnt_ff + 6'h01;
                if (hicnt_ff == 6'(scp_pkg::FLOAT_EDGES - 1))
                    nxt_float = 1'b1;
            end
            if (fall && txleft_ff != '0) begin
                nxt_out = tx_ff[scp_pkg::BYTE_W-1];
                nxt_tx = tx_ff << 1;
                nxt_txleft = txleft_ff - 4'h1;
            end else if (fall && state_ff == SCP_SHIFT && dir_ff == scp_pkg::DIR_READ
                    && oe_n_ff && bitcnt_ff == 5'(scp_pkg::HEAD_BITS)
                    && naddr_ff != scp_pkg::PTR_ADDR) begin
                nxt_out = nib_ff[naddr_ff][scp_pkg::NIB_W-1];
                nxt_tx = {nib_ff[naddr_ff] << 1, 4'h0};
                nxt_oe_n = 1'b0;
                nxt_txleft = 4'(scp_pkg::NIB_W - 1);
            end else if (fall && state_ff == SCP_SHIFT && pend_ff && dir_ff == scp_pkg::DIR_READ
                    && bitcnt_ff == 5'(scp_pkg::EXCH_BITS)) begin
                nxt_out = byte_ff[byte_pointer_nibble_ff][scp_pkg::BYTE_W-1];
                nxt_tx = byte_ff[byte_pointer_nibble_ff] << 1;
                nxt_oe_n = 1'b0;
                nxt_txleft = 4'(scp_pkg::BYTE_W - 1);
                nxt_pend = 1'b0;
            end
            // input is only taken while not driving and selected
            if (rise && oe_n_ff && !(state_ff == SCP_HOLD && dir_ff == scp_pkg::DIR_READ)) begin
                nxt_sh = {sh_ff[6:0], sin_s};
                nxt_bitcnt = bitcnt_ff + 5'h01;
                if (state_ff == SCP_IDLE)
                    nxt_state = SCP_SHIFT;
                if (state_ff == SCP_HOLD) begin
                    // split write: all eight bits are data
                    if (bitcnt_ff == 5'(scp_pkg::EXCH_BITS - 1)) begin
                        if (!BYTE_RO[byte_pointer_nibble_ff])
                            nxt_byte[byte_pointer_nibble_ff] = {sh_ff[6:0], sin_s};
                        nxt_pend = 1'b0;
                        nxt_state = SCP_IDLE;
                    end
                end else if (pend_ff && bitcnt_ff >= 5'(scp_pkg::EXCH_BITS)) begin
                    if (bitcnt_ff == 5'(2 * scp_pkg::EXCH_BITS - 1)) begin
                        if (!BYTE_RO[byte_pointer_nibble_ff])
                            nxt_byte[byte_pointer_nibble_ff] = {sh_ff[6:0], sin_s};
                        nxt_pend = 1'b0;
                    end
                end else if (bitcnt_ff == '0) begin
                    nxt_dir = sin_s;
                    nxt_pend = 1'b0;
                end else if (bitcnt_ff == 5'(scp_pkg::HEAD_BITS - 1)) begin
                    nxt_naddr = {sh_ff[1:0], sin_s};
                end else if (bitcnt_ff == 5'(scp_pkg::EXCH_BITS - 1)
                        && !(dir_ff == scp_pkg::DIR_READ && naddr_ff != scp_pkg::PTR_ADDR)) begin
                    if (naddr_ff == scp_pkg::PTR_ADDR) begin
                        nxt_ptr = {sh_ff[2:0], sin_s};
                        nxt_pend = 1'b1;
                    end else if (!NIB_RO[naddr_ff]) begin
                        nxt_nib[naddr_ff] = {sh_ff[2:0], sin_s};
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_ff <= 3'h2;
            sync2_ff <= 3'h2;
            clk_d_ff <= 1'b0;
            state_ff <= SCP_IDLE;
            bitcnt_ff <= '0;
            sh_ff <= '0;
            naddr_ff <= '0;
            dir_ff <= 1'b0;
            pend_ff <= 1'b0;
            byte_pointer_nibble_ff <= '0;
            for (int i = 0; i < scp_pkg::NIB_COUNT; i++)
                nib_ff[i] <= scp_pkg::NIB_RESET[3:0];
            for (int i = 0; i < scp_pkg::BYTE_COUNT; i++)
                byte_ff[i] <= scp_pkg::BYTE_RESET;
            tx_ff <= '0;
            txleft_ff <= '0;
            out_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            hicnt_ff <= '0;
            float_ff <= 1'b0;
            unib_ff <= '0;
            ubyte_ff <= '0;
        end else if (i_clk_en) begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            clk_d_ff <= nxt_clk_d;
            state_ff <= nxt_state;
            bitcnt_ff <= nxt_bitcnt;
            sh_ff <= nxt_sh;
            naddr_ff <= nxt_naddr;
            dir_ff <= nxt_dir;
            pend_ff <= nxt_pend;
            byte_pointer_nibble_ff <= nxt_ptr;
            nib_ff <= nxt_nib;
            byte_ff <= nxt_byte;
            tx_ff <= nxt_tx;
            txleft_ff <= nxt_txleft;
            out_ff <= nxt_out;
            oe_n_ff <= nxt_oe_n | nxt_float;
            hicnt_ff <= nxt_hicnt;
            float_ff <= nxt_float;
            unib_ff <= nxt_unib;
            ubyte_ff <= nxt_ubyte;
        end
    end

    // the port logic runs from shift clock edges found in the oversampled pin and from the synchronised select and input levels
    assign port.port_serial_out      = out_ff;
    assign port.port_serial_out_oe_n = oe_n_ff;
    assign o_user_nib                = unib_ff;
    assign o_user_byte               = ubyte_ff;
    assign o_output_float_test_mode  = float_ff;
endmodule : scp_slave
`default_nettype wire

// ---- hdl/scp_master.sv ----
// scp_master: port master; sends one 8- or 16-bit exchange per start pulse
// assumes: i_clk_sys drives a divider that makes the shift clock
`timescale 1ns/1ps
`default_nettype none
module scp_master #(
    parameter int HALF_CYC = scp_pkg::LINK_HALF_CYC
) (
    input  wire logic          i_clk_sys,
    input  wire logic          i_rst_n,
    input  wire logic          i_clk_en,
    scp_if.master              port,
    input  wire logic          i_start,
    input  wire logic          i_long,
    input  wire logic [15:0]   i_tx_word,
    output logic               o_busy,
    output logic               o_done,
    output logic [7:0]         o_rx_data
);
    logic [7:0]  div_ff, nxt_div;
    logic [4:0]  left_ff, nxt_left;
    logic [15:0] sh_ff, nxt_sh;
    logic [7:0]  rx_ff, nxt_rx;
    logic        sclk_ff, nxt_sclk, sel_n_ff, nxt_sel_n, sin_ff, nxt_sin;
    logic        busy_ff, nxt_busy, done_ff, nxt_done;
    logic [1:0]  so_s1_ff, so_s2_ff;

    always_comb begin
        nxt_div = div_ff;
        nxt_left = left_ff;
        nxt_sh = sh_ff;
        nxt_rx = rx_ff;
        nxt_sclk = sclk_ff;
        nxt_sel_n = sel_n_ff;
        nxt_sin = sin_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        if (!busy_ff) begin
            if (i_start) begin
                // enable low for exactly 8 or 16 clock periods
                nxt_left = i_long ? 5'(2 * scp_pkg::EXCH_BITS) : 5'(scp_pkg::EXCH_BITS);
                nxt_sh = i_long ? i_tx_word : {i_tx_word[7:0], 8'h00};
                nxt_sin = i_long ? i_tx_word[15] : i_tx_word[7];
                nxt_sel_n = 1'b0;
                nxt_busy = 1'b1;
                nxt_div = '0;
            end
        end else if (div_ff == 8'(HALF_CYC - 1)) begin
            nxt_div = '0;
            if (!sclk_ff) begin
                nxt_sclk = 1'b1;
                nxt_rx = {rx_ff[6:0], so_s2_ff[0] | so_s2_ff[1]};
                nxt_left = left_ff - 5'h01;
            end else begin
                nxt_sclk = 1'b0;
                nxt_sh = sh_ff << 1;
                nxt_sin = sh_ff[14];
                if (left_ff == '0) begin
                    nxt_sel_n = 1'b1;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                end
            end
        end else begin
            nxt_div = div_ff + 8'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_ff <= '0;
            left_ff <= '0;
            sh_ff <= '0;
            rx_ff <= '0;
            sclk_ff <= 1'b0;
            sel_n_ff <= 1'b1;
            sin_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            so_s1_ff <= 2'h1;
            so_s2_ff <= 2'h1;
        end else if (i_clk_en) begin
            div_ff <= nxt_div;
            left_ff <= nxt_left;
            sh_ff <= nxt_sh;
            rx_ff <= nxt_rx;
            sclk_ff <= nxt_sclk;
            sel_n_ff <= nxt_sel_n;
            sin_ff <= nxt_sin;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            so_s1_ff <= {port.port_serial_out_oe_n, port.port_serial_out};
            so_s2_ff <= so_s1_ff;
        end
    end

    assign port.port_shift_clock = sclk_ff;
    assign port.port_select_n    = sel_n_ff;
    assign port.port_serial_in   = sin_ff;
    assign o_busy                = busy_ff;
    assign o_done                = done_ff;
    assign o_rx_data             = rx_ff;
endmodule : scp_master
`default_nettype wire

// ---- testbench/scp_chk.sv ----
// scp_chk: wire-level checks on the port between the master and the slave end
// assumes: instantiated by the bench beside the interface, sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module scp_chk (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic port_shift_clock,
    input  wire logic port_select_n,
    input  wire logic port_serial_in,
    input  wire logic port_serial_out,
    input  wire logic port_serial_out_oe_n
);
    logic       sck_ff, nxt_sck, sel_ff, nxt_sel, arm_ff, nxt_arm, adir_ff, nxt_adir;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [3:0] hdr_ff, nxt_hdr, since_ff, nxt_since;
    logic       rise, fall;
    assign rise = port_shift_clock & ~sck_ff;
    assign fall = ~port_shift_clock & sck_ff;
    // bits per exchange; an 8-bit pointer exchange arms the next exchange as the byte half
    always_comb begin
        nxt_sck   = port_shift_clock;
        nxt_sel   = port_select_n;
        nxt_cnt   = port_select_n ? 5'h00 : cnt_ff + {4'h0, rise};
        nxt_hdr   = (!port_select_n && rise && cnt_ff < 5'h04) ? {hdr_ff[2:0], port_serial_in} : hdr_ff;
        nxt_since = fall ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
        nxt_arm   = arm_ff;
        nxt_adir  = adir_ff;
        if (port_select_n && !sel_ff) begin
            nxt_arm  = !arm_ff && cnt_ff == 5'h08 && hdr_ff[2:0] == 3'h7;
            nxt_adir = hdr_ff[3];
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sck_ff   <= 1'b0;
            sel_ff   <= 1'b1;
            cnt_ff   <= 5'h00;
            hdr_ff   <= 4'h0;
            since_ff <= 4'hF;
            arm_ff   <= 1'b0;
            adir_ff  <= 1'b0;
        end else begin
            sck_ff   <= nxt_sck;
            sel_ff   <= nxt_sel;
            cnt_ff   <= nxt_cnt;
            hdr_ff   <= nxt_hdr;
            since_ff <= nxt_since;
            arm_ff   <= nxt_arm;
            adir_ff  <= nxt_adir;
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence s_nib_head;
        fall && !port_select_n && !arm_ff && cnt_ff == 5'h04 && hdr_ff[3] && hdr_ff[2:0] != 3'h7;
    endsequence
    sequence s_ptr_head;
        fall && !port_select_n && !arm_ff && cnt_ff == 5'h08 && hdr_ff == 4'hF;
    endsequence
    sequence s_drive;
        !port_serial_out_oe_n;
    endsequence
    a_float_on_deselect: assert property ($rose(port_select_n) |-> ##[1:6] port_serial_out_oe_n)
        else $error("serial output still driven after deselect");
    a_idle_floats: assert property (port_select_n [*8] |-> port_serial_out_oe_n)
        else $error("serial output driven while deselected");
    a_write_floats: assert property (!port_select_n && (arm_ff ? !adir_ff :
        (cnt_ff >= 5'h04 && !hdr_ff[3])) |-> port_serial_out_oe_n) else $error("serial output driven in a write");
    a_head_floats: assert property (!port_select_n && !arm_ff && cnt_ff < 5'h04 |-> port_serial_out_oe_n)
        else $error("serial output driven during the header");
    a_nib_read_drive: assert property (s_nib_head |-> ##[1:6] s_drive)
        else $error("nibble read data not driven after fourth edge");
    a_byte_read_drive: assert property (s_ptr_head |-> ##[1:6] s_drive)
        else $error("byte read data not driven after eighth edge");
    a_split_read_msb: assert property ($fell(port_select_n) && arm_ff && adir_ff |-> ##[1:6] s_drive)
        else $error("split read byte not presented on reselect");
    a_out_after_fall: assert property (!port_serial_out_oe_n && !$past(port_serial_out_oe_n)
        && $changed(port_serial_out) |-> since_ff < 4'h8) else $error("serial output changed away from a falling edge");
endmodule : scp_chk
`default_nettype wire

// ---- testbench/test_serial_control_port_slave.sv ----
// test_serial_control_port_slave: master and slave joined, plus a bench-driven slave for faults
// assumes: package, interface, both design ends and the checker compiled first
`timescale 1ns/1ps
`default_nettype none
module test_serial_control_port_slave;
    typedef struct {logic [1:0] kind; logic [7:0] val;} scp_note_t;
    logic        clk = 1'b0, rst_n = 1'b0, start = 1'b0, lng = 1'b0, busy, done, mode, mode2;
    logic [15:0] word = 16'h0000;
    logic [7:0]  rx, ubyte;
    logic [3:0]  unib, unib2, byte_sel = 4'h0;
    logic [2:0]  nib_sel = 3'h0;
    logic [31:0] seed = 32'h000099C8;
    logic [7:0]  nib_exp [8];
    scp_note_t   q [$];
    scp_note_t   n;
    int          miscompares = 0, num_checks = 0, cycles = 0;
    scp_if bus ();
    scp_if flt ();
    scp_master #(.HALF_CYC(10)) scp_master_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
        .port(bus.master), .i_start(start), .i_long(lng), .i_tx_word(word), .o_busy(busy), .o_done(done),
        .o_rx_data(rx));
    scp_slave scp_slave_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .port(bus.slave),
        .i_user_nib_sel(nib_sel), .i_user_byte_sel(byte_sel), .o_user_nib(unib), .o_user_byte(ubyte),
        .o_output_float_test_mode(mode));
    scp_slave flt_scp_slave_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .port(flt.slave),
        .i_user_nib_sel(nib_sel), .i_user_byte_sel(byte_sel), .o_user_nib(unib2), .o_user_byte(),
        .o_output_float_test_mode(mode2));
    scp_chk scp_chk_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .port_shift_clock(bus.port_shift_clock),
        .port_select_n(bus.port_select_n), .port_serial_in(bus.port_serial_in),
        .port_serial_out(bus.port_serial_out), .port_serial_out_oe_n(bus.port_serial_out_oe_n));
    always #2 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // one exchange by the master end; the note is judged by the watcher after done
    task automatic xfer(input logic l, input logic [15:0] w, input logic [1:0] k, input logic [7:0] e);
        q.push_back('{k, e});
        start = 1'b1;
        lng = l;
        word = w;
        @(negedge clk);
        start = 1'b0;
        for (int i = 0; i < 1000 && done !== 1'b1; i++) @(negedge clk);
        check({7'h00, done}, 8'h01);
        repeat (8) @(negedge clk);
    endtask : xfer
    // one bit by the bench acting as master, 80 ns shift clock
    task automatic fbit(input logic b);
        flt.port_serial_in = b;
        repeat (10) @(negedge clk);
        flt.port_shift_clock = 1'b1;
        repeat (10) @(negedge clk);
        flt.port_shift_clock = 1'b0;
    endtask : fbit
    task automatic fsend(input logic [7:0] v, input int nb);
        for (int i = 7; i > 7 - nb; i--) fbit(v[i]);
    endtask : fsend
    always @(negedge clk) begin
        if (done === 1'b1) begin
            repeat (4) @(negedge clk);
            n = q.pop_front();
            check({6'h00, busy, mode}, 8'h00);
            if (n.kind == 2'h0) check(rx, n.val);
            else if (n.kind == 2'h1) check({4'h0, unib}, n.val);
            else if (n.kind == 2'h2) check(ubyte, n.val);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            stop_test();
        end
    end
    initial begin
        flt.port_shift_clock = 1'b0;
        flt.port_select_n = 1'b1;
        flt.port_serial_in = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        for (int a = 0; a < 7; a++) begin
            seed = xs(seed);
            nib_sel = a[2:0];
            nib_exp[a] = {4'hF, seed[3:0]};
            xfer(1'b0, {8'h00, 1'b0, a[2:0], seed[3:0]}, 2'h1, {4'h0, seed[3:0]});
        end
        for (int a = 0; a < 7; a++) xfer(1'b0, {8'h00, 1'b1, a[2:0], seed[7:4]}, 2'h0, nib_exp[a]);
        for (int p = 0; p < 16; p++) begin
            seed = xs(seed);
            byte_sel = p[3:0];
            if (p[0]) begin
                xfer(1'b0, {8'h00, 4'h7, p[3:0]}, 2'h3, 8'h00);
                xfer(1'b0, {8'h00, seed[7:0]}, 2'h2, seed[7:0]);
            end else xfer(1'b1, {4'h7, p[3:0], seed[7:0]}, 2'h2, seed[7:0]);
            if (p[1]) begin
                xfer(1'b0, {8'h00, 4'hF, p[3:0]}, 2'h3, 8'h00);
                xfer(1'b0, {8'h00, seed[15:8]}, 2'h0, seed[7:0]);
            end else xfer(1'b1, {4'hF, p[3:0], seed[15:8]}, 2'h0, seed[7:0]);
        end
        nib_sel = 3'h0;
        flt.port_select_n = 1'b0;
        fsend(8'h0A, 6);
        flt.port_select_n = 1'b1;
        repeat (10) @(negedge clk);
        check({4'h0, unib2}, 8'h00);
        fsend(8'h0F, 8);
        repeat (10) @(negedge clk);
        check({4'h0, unib2}, 8'h00);
        flt.port_select_n = 1'b0;
        fsend(8'h09, 8);
        flt.port_select_n = 1'b1;
        repeat (10) @(negedge clk);
        check({4'h0, unib2}, 8'h09);
        flt.port_select_n = 1'b0;
        fsend(8'h80, 4);
        repeat (6) @(negedge clk);
        check({6'h00, flt.port_serial_out_oe_n, flt.port_serial_out}, 8'h01);
        flt.port_select_n = 1'b1;
        repeat (6) @(negedge clk);
        check({7'h00, flt.port_serial_out_oe_n}, 8'h01);
        flt.port_select_n = 1'b0;
        repeat (32) fbit(1'b1);
        repeat (10) @(negedge clk);
        check({7'h00, mode2}, 8'h00);
        fbit(1'b1);
        repeat (10) @(negedge clk);
        check({6'h00, mode2, flt.port_serial_out_oe_n}, 8'h03);
        flt.port_serial_in = 1'b0;
        repeat (10) @(negedge clk);
        check({7'h00, mode2}, 8'h00);
        repeat (33) fbit(1'b1);
        repeat (10) @(negedge clk);
        check({7'h00, mode2}, 8'h01);
        flt.port_select_n = 1'b1;
        repeat (10) @(negedge clk);
        check({7'h00, mode2}, 8'h00);
        stop_test();
    end
endmodule : test_serial_control_port_slave
`default_nettype wire
